// ==== verilog/ehfdbc_consts.svh ====
`ifndef EHFDBC_CONSTS_SVH
`define EHFDBC_CONSTS_SVH

// Register byte offsets
`define EHFDBC_OFS_HASH_UPPER 8'h00
`define EHFDBC_OFS_HASH_LOWER 8'h04
`define EHFDBC_OFS_FILTER_CFG 8'h08
`define EHFDBC_OFS_BUS_CFG 8'h0c
`define EHFDBC_OFS_BURST_CFG 8'h10
`define EHFDBC_OFS_DESC_GAP 8'h14
`define EHFDBC_OFS_STATUS 8'h18

// Filter configuration bits
`define EHFDBC_FLT_UNICAST_HASH 0
`define EHFDBC_FLT_MULTICAST_HASH 1
`define EHFDBC_FLT_COMBINE 2
`define EHFDBC_FLT_INVERSE_DEST 3
`define EHFDBC_FLT_WIDTH 4

// Bus configuration fields
`define EHFDBC_BUS_WEIGHT_LSB 0
`define EHFDBC_BUS_RATIO_LSB 2
`define EHFDBC_BUS_TX_FIRST 4
`define EHFDBC_BUS_STRICT 5
`define EHFDBC_BUS_ALIGNED 6
`define EHFDBC_BUS_CONSTANT 7
`define EHFDBC_BUS_VARIABLE 8
`define EHFDBC_BUS_EXTENDED 9
`define EHFDBC_BUS_WIDTH 10

// Burst configuration fields
`define EHFDBC_BURST_RX_LSB 0
`define EHFDBC_BURST_TX_LSB 8
`define EHFDBC_BURST_W 6
`define EHFDBC_BURST_RESET 6'h01

// Descriptor geometry in 32-bit words
`define EHFDBC_GAP_W 5
`define EHFDBC_DESC_BASIC_WORDS 6'h04
`define EHFDBC_DESC_EXT_WORDS 6'h08

// Hash CRC constants
`define EHFDBC_CRC_POLY 32'hedb88320
`define EHFDBC_CRC_INIT 32'hffffffff

`endif

// ==== verilog/ehfdbc_pkg.sv ====
package ehfdbc_pkg;

  // Owner of the system-side bus
  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_RX,
    ARB_TX
  } ehfdbc_arb_t;

  // Burst kind handed to the DMA engines
  typedef enum logic [1:0] {
    BURST_SINGLE,
    BURST_FIXED,
    BURST_OPEN
  } ehfdbc_burst_t;

endpackage

// ==== verilog/ehfdbc_crc_hash.sv ====
`timescale 1ns/1ps
`include "ehfdbc_consts.svh"

module ehfdbc_crc_hash
  import ehfdbc_pkg::*;
(
  // Six address bytes, first transmitted byte in bits 7:0
  input wire logic [47:0] addr,
  // Hash table index
  output logic [5:0] hash_index
);

  logic [31:0] crc;

  // Reflected CRC-32, bytes in wire order, each byte LSB first
  always_comb begin
    crc = `EHFDBC_CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      if (crc[0] ^ addr[i]) begin
        crc = (crc >> 1) ^ `EHFDBC_CRC_POLY;
      end else begin
        crc = crc >> 1;
      end
    end
    crc = ~crc;
  end

  // Lowest six bits of the finished CRC form the index
  assign hash_index = crc[5:0];

endmodule

// ==== verilog/ehfdbc_top.sv ====
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ehfdbc_consts.svh"

// What this block does
// - Hash table is 64 bits, an upper and lower 32-bit word, software read/write.
// - CRC over source or destination address; lowest 6 bits index the table.
// - Index bit 5 picks upper or lower word; bits 4:0 pick the bit.
// - Normal filtering passes on indexed bit one, rejects on zero.
// - Hash used only when unicast or multicast hash option is enabled.
// - Channel priority weight field selects a weight of 1 to 4.
// - Weighted grant ratio 1:1 to 4:1, rx favoured unless transmit-first set.
// - Strict arbitration ignores the programmed grant ratio.
// - Strict arbitration: rx always wins, or tx when transmit-first set.
// - Without strict arbitration use weighted round-robin from ratio and option.
// - Aligned plus constant aligns every burst; aligned alone aligns all but first.
// - Extended descriptor layout when its option is set, basic layout otherwise.
// - Constant burst option makes every burst fixed length.
// - Variable burst option picks burst type from remaining data length.
// - Separate rx and tx max bursts; only 1,2,4,8,16,32 are legal.
// - Ring mode wraps on ring flag; chained mode follows next pointer.
// - Ring mode skips 0 to 31 words after the descriptor fields.
// - Inverse destination filtering inverts the destination pass sense, hash included.
// - Combine option passes destination checks when perfect or enabled hash filter passes.
module ehfdbc_top
  import ehfdbc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Address filter request
  input wire logic flt_valid,
  input wire logic [47:0] flt_addr,
  input wire logic flt_is_dest,
  input wire logic flt_perfect_pass,
  output logic flt_done,
  output logic flt_pass,
  output logic [5:0] flt_hash_index,
  // System bus arbitration
  input wire logic rx_req,
  input wire logic tx_req,
  input wire logic bus_done,
  output logic rx_gnt,
  output logic tx_gnt,
  output logic [2:0] channel_weight,
  // Burst planning
  input wire logic brst_valid,
  input wire logic brst_is_tx,
  input wire logic brst_first,
  input wire logic [31:0] brst_addr,
  input wire logic [15:0] brst_remaining,
  output logic brst_done,
  output logic [5:0] brst_len,
  output ehfdbc_burst_t brst_kind,
  // Descriptor stepping
  input wire logic desc_valid,
  input wire logic desc_chained,
  input wire logic ring_wrap_flag,
  input wire logic [31:0] desc_cur_addr,
  input wire logic [31:0] desc_next_ptr,
  input wire logic [31:0] desc_ring_base,
  output logic desc_done,
  output logic [31:0] desc_next_addr,
  output logic [5:0] desc_words
);

  // Software registers
  logic [31:0] hash_table_upper_word_r;
  logic [31:0] hash_table_lower_word_r;
  logic [`EHFDBC_FLT_WIDTH-1:0] filter_cfg_r;
  logic [`EHFDBC_BUS_WIDTH-1:0] bus_cfg_r;
  logic [`EHFDBC_BURST_W-1:0] receive_max_burst_r;
  logic [`EHFDBC_BURST_W-1:0] transmit_max_burst_r;
  logic [`EHFDBC_GAP_W-1:0] descriptor_gap_words_r;

  // Named configuration fields
  logic unicast_hash_enable;
  logic multicast_hash_enable;
  logic combine_filters_enable;
  logic inverse_dest_filter;
  logic [1:0] channel_weight_select;
  logic [1:0] grant_ratio_select;
  logic transmit_first_option;
  logic strict_arbitration_option;
  logic aligned_burst_option;
  logic constant_burst_option;
  logic variable_burst_option;
  logic extended_descriptor_option;

  assign unicast_hash_enable = filter_cfg_r[`EHFDBC_FLT_UNICAST_HASH];
  assign multicast_hash_enable = filter_cfg_r[`EHFDBC_FLT_MULTICAST_HASH];
  assign combine_filters_enable = filter_cfg_r[`EHFDBC_FLT_COMBINE];
  assign inverse_dest_filter = filter_cfg_r[`EHFDBC_FLT_INVERSE_DEST];
  assign channel_weight_select = bus_cfg_r[`EHFDBC_BUS_WEIGHT_LSB +: 2];
  assign grant_ratio_select = bus_cfg_r[`EHFDBC_BUS_RATIO_LSB +: 2];
  assign transmit_first_option = bus_cfg_r[`EHFDBC_BUS_TX_FIRST];
  assign strict_arbitration_option = bus_cfg_r[`EHFDBC_BUS_STRICT];
  assign aligned_burst_option = bus_cfg_r[`EHFDBC_BUS_ALIGNED];
  assign constant_burst_option = bus_cfg_r[`EHFDBC_BUS_CONSTANT];
  assign variable_burst_option = bus_cfg_r[`EHFDBC_BUS_VARIABLE];
  assign extended_descriptor_option = bus_cfg_r[`EHFDBC_BUS_EXTENDED];

  // Register writes; the DMA side assumes software keeps this stable while active
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hash_table_upper_word_r <= 32'h00000000;
      hash_table_lower_word_r <= 32'h00000000;
      filter_cfg_r <= '0;
      bus_cfg_r <= '0;
      receive_max_burst_r <= `EHFDBC_BURST_RESET;
      transmit_max_burst_r <= `EHFDBC_BURST_RESET;
      descriptor_gap_words_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `EHFDBC_OFS_HASH_UPPER) begin
        hash_table_upper_word_r <= reg_wdata;
      end else if (reg_addr == `EHFDBC_OFS_HASH_LOWER) begin
        hash_table_lower_word_r <= reg_wdata;
      end else if (reg_addr == `EHFDBC_OFS_FILTER_CFG) begin
        filter_cfg_r <= reg_wdata[`EHFDBC_FLT_WIDTH-1:0];
      end else if (reg_addr == `EHFDBC_OFS_BUS_CFG) begin
        bus_cfg_r <= reg_wdata[`EHFDBC_BUS_WIDTH-1:0];
      end else if (reg_addr == `EHFDBC_OFS_BURST_CFG) begin
        receive_max_burst_r <= reg_wdata[`EHFDBC_BURST_RX_LSB +: `EHFDBC_BURST_W];
        transmit_max_burst_r <= reg_wdata[`EHFDBC_BURST_TX_LSB +: `EHFDBC_BURST_W];
      end else if (reg_addr == `EHFDBC_OFS_DESC_GAP) begin
        descriptor_gap_words_r <= reg_wdata[`EHFDBC_GAP_W-1:0];
      end
    end
  end

  // Legal burst lengths are a single power of two up to 32
  function automatic logic burst_legal(input logic [5:0] v);
    burst_legal = (v != 6'h00) && ((v & (v - 6'h01)) == 6'h00);
  endfunction

  // Sticky observation of the last filter result, plus the live grant state
  logic last_pass_r;
  logic [5:0] last_index_r;
  ehfdbc_arb_t arb_state_r;

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == `EHFDBC_OFS_HASH_UPPER) begin
        reg_rdata <= hash_table_upper_word_r;
      end else if (reg_addr == `EHFDBC_OFS_HASH_LOWER) begin
        reg_rdata <= hash_table_lower_word_r;
      end else if (reg_addr == `EHFDBC_OFS_FILTER_CFG) begin
        reg_rdata <= {28'h0000000, filter_cfg_r};
      end else if (reg_addr == `EHFDBC_OFS_BUS_CFG) begin
        reg_rdata <= {22'h000000, bus_cfg_r};
      end else if (reg_addr == `EHFDBC_OFS_BURST_CFG) begin
        reg_rdata <= {18'h00000, transmit_max_burst_r, 2'h0, receive_max_burst_r};
      end else if (reg_addr == `EHFDBC_OFS_DESC_GAP) begin
        reg_rdata <= {27'h0000000, descriptor_gap_words_r};
      end else if (reg_addr == `EHFDBC_OFS_STATUS) begin
        reg_rdata <= {18'h00000, (arb_state_r == ARB_TX), (arb_state_r == ARB_RX),
                      ~burst_legal(transmit_max_burst_r), ~burst_legal(receive_max_burst_r),
                      1'b0, last_pass_r, 2'h0, last_index_r};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // Weight 1..4 is the field plus one
  assign channel_weight = {1'b0, channel_weight_select} + 3'h1;

  // Hash lookup
  logic [5:0] hash_index;
  logic hash_hit;
  logic is_multicast;
  logic hash_enable;
  logic filter_result;

  ehfdbc_crc_hash u_crc_hash (
    .addr(flt_addr),
    .hash_index(hash_index)
  );

  // Bit 5 picks the word, bits 4:0 the bit within it
  assign hash_hit = hash_index[5] ? hash_table_upper_word_r[hash_index[4:0]]
                                  : hash_table_lower_word_r[hash_index[4:0]];
  // Group bit is the LSB of the first byte on the wire
  assign is_multicast = flt_addr[0];
  assign hash_enable = is_multicast ? multicast_hash_enable : unicast_hash_enable;

  // Pass decision; inversion applies to destination checks only
  always_comb begin
    filter_result = flt_perfect_pass;
    if (hash_enable) begin
      if (combine_filters_enable && flt_is_dest) begin
        filter_result = hash_hit | flt_perfect_pass;
      end else begin
        filter_result = hash_hit;
      end
    end
    if (flt_is_dest && inverse_dest_filter) begin
      filter_result = ~filter_result;
    end
  end

  // Filter answer one cycle after the request
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flt_done <= 1'b0;
      flt_pass <= 1'b0;
      flt_hash_index <= 6'h00;
    end else begin
      flt_done <= flt_valid;
      if (flt_valid) begin
        flt_pass <= filter_result;
        flt_hash_index <= hash_index;
      end
    end
  end

  // Last result kept for software inspection
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      last_pass_r <= 1'b0;
      last_index_r <= 6'h00;
    end else if (flt_valid) begin
      last_pass_r <= filter_result;
      last_index_r <= hash_index;
    end
  end

  // Arbitration: favoured channel wins ratio+1 grants before the other gets one
  logic [2:0] fav_cnt_r;
  logic fav_req;
  logic oth_req;
  logic pick_fav;
  logic [2:0] ratio_limit;

  assign fav_req = transmit_first_option ? tx_req : rx_req;
  assign oth_req = transmit_first_option ? rx_req : tx_req;
  assign ratio_limit = {1'b0, grant_ratio_select} + 3'h1;

  always_comb begin
    if (strict_arbitration_option) begin
      pick_fav = fav_req;
    end else if (fav_req && oth_req) begin
      pick_fav = (fav_cnt_r < ratio_limit);
    end else begin
      pick_fav = fav_req;
    end
  end

  // Grant held until the owner reports the transaction done
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      arb_state_r <= ARB_IDLE;
      fav_cnt_r <= 3'h0;
    end else begin
      case (arb_state_r)
        ARB_IDLE: begin
          if (fav_req || oth_req) begin
            if (pick_fav ^ transmit_first_option) begin
              arb_state_r <= ARB_RX;
            end else begin
              arb_state_r <= ARB_TX;
            end
            if (strict_arbitration_option) begin
              fav_cnt_r <= 3'h0;
            end else if (pick_fav && oth_req) begin
              fav_cnt_r <= fav_cnt_r + 3'h1;
            end else if (!pick_fav) begin
              fav_cnt_r <= 3'h0;
            end
          end
        end
        ARB_RX, ARB_TX: begin
          if (bus_done) begin
            arb_state_r <= ARB_IDLE;
          end
        end
        default: begin
          arb_state_r <= ARB_IDLE;
        end
      endcase
    end
  end

  assign rx_gnt = (arb_state_r == ARB_RX);
  assign tx_gnt = (arb_state_r == ARB_TX);

  // Burst planning
  logic [5:0] max_burst;
  logic [5:0] to_boundary;
  logic [5:0] len_calc;
  logic align_now;
  logic covers_max;
  ehfdbc_burst_t kind_calc;

  assign max_burst = brst_is_tx ? transmit_max_burst_r : receive_max_burst_r;
  // Words left to the end of a max-sized window; max is a power of two
  assign to_boundary = max_burst - (brst_addr[7:2] & (max_burst - 6'h01));
  assign align_now = aligned_burst_option && (constant_burst_option || !brst_first);
  assign covers_max = (brst_remaining >= {10'h000, max_burst});

  always_comb begin
    len_calc = covers_max ? max_burst : brst_remaining[5:0];
    if (constant_burst_option) begin
      len_calc = max_burst;
      kind_calc = BURST_FIXED;
    end else if (variable_burst_option) begin
      kind_calc = covers_max ? BURST_FIXED : BURST_OPEN;
    end else begin
      kind_calc = BURST_OPEN;
    end
    if (align_now && (to_boundary < len_calc)) begin
      len_calc = to_boundary;
    end
    if (len_calc == 6'h01) begin
      kind_calc = BURST_SINGLE;
    end
  end

  // Burst plan answer one cycle after the request
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      brst_done <= 1'b0;
      brst_len <= 6'h00;
      brst_kind <= BURST_SINGLE;
    end else begin
      brst_done <= brst_valid;
      if (brst_valid) begin
        brst_len <= len_calc;
        brst_kind <= kind_calc;
      end
    end
  end

  // Descriptor stepping
  logic [5:0] layout_words;
  logic [6:0] stride_words;
  logic [31:0] stride_bytes;

  assign layout_words = extended_descriptor_option ? `EHFDBC_DESC_EXT_WORDS
                                                   : `EHFDBC_DESC_BASIC_WORDS;
  // Seven bits hold the worst case of eight layout words plus a 31-word gap
  assign stride_words = {1'b0, layout_words} + {2'h0, descriptor_gap_words_r};
  assign stride_bytes = {23'h0, stride_words, 2'h0};
  assign desc_words = layout_words;

  // Next descriptor address one cycle after the request
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      desc_done <= 1'b0;
      desc_next_addr <= 32'h00000000;
    end else begin
      desc_done <= desc_valid;
      if (desc_valid) begin
        if (desc_chained) begin
          desc_next_addr <= desc_next_ptr;
        end else if (ring_wrap_flag) begin
          desc_next_addr <= desc_ring_base;
        end else begin
          desc_next_addr <= desc_cur_addr + stride_bytes;
        end
      end
    end
  end

endmodule

// ==== verif/ehfdbc_props.sv ====
`timescale 1ns/1ps

module ehfdbc_props
  import ehfdbc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Filter and arbiter
  input wire logic flt_valid,
  input wire logic flt_done,
  input wire logic tx_req,
  input wire logic bus_done,
  input wire logic rx_gnt,
  input wire logic tx_gnt,
  input wire logic [2:0] channel_weight,
  // Burst and descriptor
  input wire logic brst_valid,
  input wire logic brst_done,
  input wire logic [5:0] brst_len,
  input wire ehfdbc_burst_t brst_kind,
  input wire logic desc_valid,
  input wire logic desc_chained,
  input wire logic [31:0] desc_next_ptr,
  input wire logic desc_done,
  input wire logic [31:0] desc_next_addr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Filter answers in the next cycle
  property p_flt_ans;
    flt_valid |=> flt_done;
  endproperty
  a_flt_ans: assert property (p_flt_ans) else $error("filter answer missing");
  // One owner at a time, released on the end of a transaction
  property p_gnt_one;
    !(rx_gnt && tx_gnt);
  endproperty
  a_gnt_one: assert property (p_gnt_one) else $error("both channels granted");
  property p_gnt_end;
    (rx_gnt || tx_gnt) && bus_done |=> !rx_gnt && !tx_gnt;
  endproperty
  a_gnt_end: assert property (p_gnt_end) else $error("grant outlived transaction");
  property p_gnt_cause;
    $rose(tx_gnt) |-> $past(tx_req);
  endproperty
  a_gnt_cause: assert property (p_gnt_cause) else $error("tx granted unasked");
  property p_weight;
    channel_weight inside {[3'h1:3'h4]};
  endproperty
  a_weight: assert property (p_weight) else $error("weight out of range");
  // Burst plans stay within 1 to 32 words
  property p_brst;
    brst_valid |=> brst_done && brst_len inside {[6'h01:6'h20]};
  endproperty
  a_brst: assert property (p_brst) else $error("burst plan wrong");
  property p_single;
    brst_done && brst_len == 6'h01 |-> brst_kind == BURST_SINGLE;
  endproperty
  a_single: assert property (p_single) else $error("one word not single");
  // Chained step follows the pointer whatever the wrap flag
  property p_chain;
    desc_valid && desc_chained |=> desc_done && desc_next_addr == $past(desc_next_ptr);
  endproperty
  a_chain: assert property (p_chain) else $error("chain pointer not taken");
endmodule

// ==== verif/ehfdbc_bus_model.sv ====
`timescale 1ns/1ps

module ehfdbc_bus_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Grants from the arbiter
  input wire logic rx_gnt,
  input wire logic tx_gnt,
  // End of transaction
  output logic bus_done
);
  logic [2:0] beat_r;
  // Rx ends fast, tx slowly, so both latencies are seen
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      beat_r <= 3'h0;
      bus_done <= 1'b0;
    end else begin
      bus_done <= 1'b0;
      if ((rx_gnt || tx_gnt) && !bus_done) begin
        beat_r <= beat_r + 3'h1;
        if (beat_r == (tx_gnt ? 3'h4 : 3'h1)) begin
          beat_r <= 3'h0;
          bus_done <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== verif/test_ehfdbc_top.sv ====
`timescale 1ns/1ps
`include "ehfdbc_consts.svh"

module test_ehfdbc_top
  import ehfdbc_pkg::*;
;
  localparam logic [31:0] HUP = 32'h0f0f3c3c;
  localparam logic [31:0] HLO = 32'h5555aaaa;
  localparam logic [7:0] OFS [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  localparam logic [31:0] MSK [6] = '{'1, '1, 32'hf, 32'h3ff, 32'h3f3f, 32'h1f};
  localparam logic [15:0] REM [4] = '{16'h1, 16'h5, 16'h28, 16'h20};
  logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, flt_valid = 0, flt_is_dest = 0;
  logic flt_perfect_pass = 0, rx_req = 0, tx_req = 0, brst_valid = 0, brst_is_tx = 0;
  logic brst_first = 0, desc_valid = 0, desc_chained = 0, ring_wrap_flag = 0;
  logic flt_done, flt_pass, bus_done, rx_gnt, tx_gnt, brst_done, desc_done, t;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, brst_addr = 0, desc_cur_addr = 32'h1000;
  logic [31:0] desc_next_ptr = 32'h8000, desc_ring_base = 32'h4000, reg_rdata, desc_next_addr;
  logic [47:0] flt_addr = 0;
  logic [15:0] brst_remaining = 0;
  logic [5:0] flt_hash_index, brst_len, desc_words;
  logic [2:0] channel_weight;
  ehfdbc_burst_t brst_kind;
  logic [31:0] st_exp = 0;
  int mismatches = 0, n_tests = 0;
  ehfdbc_top dut_u (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .flt_valid, .flt_addr, .flt_is_dest, .flt_perfect_pass, .flt_done, .flt_pass,
    .flt_hash_index, .rx_req, .tx_req, .bus_done, .rx_gnt, .tx_gnt, .channel_weight,
    .brst_valid, .brst_is_tx, .brst_first, .brst_addr, .brst_remaining, .brst_done, .brst_len,
    .brst_kind, .desc_valid, .desc_chained, .ring_wrap_flag, .desc_cur_addr, .desc_next_ptr,
    .desc_ring_base, .desc_done, .desc_next_addr, .desc_words);
  ehfdbc_bus_model bus_u (.core_clk, .rstn, .rx_gnt, .tx_gnt, .bus_done);
  // Clock
  always #5 core_clk = ~core_clk;
  // Compare and report helpers
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Register port: one-cycle strobes, read data from the next cycle, held until the next read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask
  // Filter request against a bench-side CRC
  task automatic flt(input logic [47:0] a, input logic dst, input logic pp, input logic [3:0] c);
    logic [31:0] crc;
    logic fb, e;
    crc = `EHFDBC_CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      fb = crc[0] ^ a[i];
      crc = (crc >> 1) ^ (fb ? `EHFDBC_CRC_POLY : 32'h0);
    end
    crc = ~crc;
    e = crc[5] ? HUP[crc[4:0]] : HLO[crc[4:0]];
    e = (a[0] ? c[1] : c[0]) ? ((c[2] && dst) ? (e | pp) : e) : pp;
    @(posedge core_clk);
    {flt_valid, flt_addr, flt_is_dest, flt_perfect_pass} <= {1'b1, a, dst, pp};
    @(posedge core_clk);
    flt_valid <= 1'b0;
    #1 chk("flt_done", flt_done, 1'b1);
    chk("flt_hash_index", flt_hash_index, crc[5:0]);
    chk("flt_pass", flt_pass, e ^ (dst & c[3]));
    st_exp = {23'h0, e ^ (dst & c[3]), 2'h0, crc[5:0]};
  endtask
  // Grant waits, bounded
  task automatic await(input logic busy);
    for (int n = 0; ((rx_gnt === 1'b1) || (tx_gnt === 1'b1)) !== busy; n++) begin
      if (n == 40) begin
        chk("grant wait", 1'b0, 1'b1);
        stop_test();
      end
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic grant(output logic g);
    #1 await(1'b1);
    g = tx_gnt;
    await(1'b0);
  endtask
  task automatic idle();
    @(posedge core_clk);
    {rx_req, tx_req} <= 2'b00;
    #1 await(1'b0);
  endtask
  // Burst plan with the expected length and kind
  task automatic brst(input logic tx, input logic f, input logic [31:0] ad,
                      input logic [15:0] rem, input logic [2:0] o);
    logic [15:0] mx, ln;
    ehfdbc_burst_t k;
    mx = tx ? 16'h20 : 16'h08;
    ln = (rem < mx) ? rem : mx;
    k = (o[2] && rem >= mx) ? BURST_FIXED : BURST_OPEN;
    if (o[1]) begin
      ln = mx;
      k = BURST_FIXED;
    end
    if (o[0] && (o[1] || !f) && ln > mx - (ad[7:2] & (mx - 1))) ln = mx - (ad[7:2] & (mx - 1));
    if (ln == 16'h1) k = BURST_SINGLE;
    @(posedge core_clk);
    {brst_valid, brst_is_tx, brst_first, brst_addr, brst_remaining} <= {1'b1, tx, f, ad, rem};
    @(posedge core_clk);
    brst_valid <= 1'b0;
    #1 chk("brst_done", brst_done, 1'b1);
    chk("brst_len", brst_len, ln);
    chk("brst_kind", brst_kind, k);
  endtask
  // Descriptor step
  task automatic desc(input logic ch, input logic wf, input logic ext, input logic [4:0] gap);
    logic [5:0] w;
    w = ext ? `EHFDBC_DESC_EXT_WORDS : `EHFDBC_DESC_BASIC_WORDS;
    @(posedge core_clk);
    {desc_valid, desc_chained, ring_wrap_flag} <= {1'b1, ch, wf};
    @(posedge core_clk);
    desc_valid <= 1'b0;
    #1 chk("desc_done", desc_done, 1'b1);
    chk("desc_words", desc_words, w);
    chk("desc_next_addr", desc_next_addr,
        ch ? 32'h8000 : wf ? 32'h4000 : 32'h1000 + 32'h4 * (w + gap));
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_chk(OFS[i], (i == 4) ? 32'h0101 : 32'h0);
      wr(OFS[i], '1);
      rd_chk(OFS[i], MSK[i]);
    end
    rd_chk(8'h18, 32'h0c00);
    wr(8'h1c, '1);
    rd_chk(8'h1c, 32'h0);
    wr(8'h00, HUP);
    wr(8'h04, HLO);
    wr(8'h10, 32'h2008);
    rd_chk(8'h00, HUP);
    rd_chk(8'h04, HLO);
    rd_chk(8'h18, 32'h0);
    $display("test registers done");
    for (int c = 0; c < 16; c++) begin
      wr(8'h08, c);
      for (int i = 0; i < 16; i++) begin
        flt(48'h0123456789 + i * 48'h1000015, i[1], i[2], c[3:0]);
      end
    end
    rd_chk(8'h18, st_exp);
    $display("test filter done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h0c, s);
      #1 chk("channel_weight", channel_weight, s + 1);
    end
    for (int tf = 0; tf < 2; tf++) begin
      for (int r = 0; r < 4; r++) begin
        // Bus settings written afresh before each scenario, as software must
        wr(8'h0c, 32'h20 | (tf << 4) | (r << 2));
        {rx_req, tx_req} <= 2'b11;
        repeat (3) begin
          grant(t);
          chk("tx_gnt", t, tf);
        end
        {rx_req, tx_req} <= tf ? 2'b10 : 2'b01;
        grant(t);
        chk("tx_gnt", t, !tf);
        idle();
        wr(8'h0c, (tf << 4) | (r << 2));
        {rx_req, tx_req} <= 2'b11;
        for (int i = 0; i < r + 2; i++) begin
          grant(t);
          chk("tx_gnt", t, (i == r + 1) ? !tf : tf);
        end
        idle();
      end
    end
    $display("test arbiter done");
    for (int o = 0; o < 8; o++) begin
      wr(8'h0c, o << 6);
      for (int j = 0; j < 32; j++) begin
        brst(j[0], j[1], j[2] ? 32'h14 : 32'h0, REM[j[4:3]], o[2:0]);
      end
    end
    $display("test burst done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h0c, {22'h0, k[0], 9'h0});
      wr(8'h14, k[1] ? 32'h1f : 32'h0);
      desc(1'b0, 1'b0, k[0], k[1] ? 5'h1f : 5'h0);
      desc(1'b0, 1'b1, k[0], 5'h0);
      desc(1'b1, 1'b1, k[0], 5'h0);
    end
    $display("test descriptor done");
    stop_test();
  end
endmodule

bind ehfdbc_top ehfdbc_props props_u (.core_clk, .rstn, .flt_valid, .flt_done, .tx_req,
  .bus_done, .rx_gnt, .tx_gnt, .channel_weight, .brst_valid, .brst_done, .brst_len,
  .brst_kind, .desc_valid, .desc_chained, .desc_next_ptr, .desc_done, .desc_next_addr);
